// *** inc/clock_gen_params.svh ***
// Constants for the clock generator output control: offsets, fields, resets
`ifndef CLOCK_GEN_PARAMS_SVH
`define CLOCK_GEN_PARAMS_SVH

// ************************************************************
// Serial slave
// ************************************************************
`define CG_SLAVE_ADDR 8'hD2
`define CG_BITS_PER_BYTE 4'h8
`define CG_MAX_BYTES 4'hA
`define CG_FIRST_DATA 4'h3
`define CG_NUM_REGS 4'h7

// ************************************************************
// Register byte indices
// ************************************************************
`define CG_BYTE_FUNC 3'h0
`define CG_BYTE_CPU 3'h1
`define CG_BYTE_PCI 3'h2
`define CG_BYTE_SDRAM_LO 3'h3
`define CG_BYTE_SDRAM_HI 3'h4
`define CG_BYTE_PERIPH 3'h5

// ************************************************************
// Field positions
// ************************************************************
`define CG_FUNC_MSB 1
`define CG_FUNC_LSB 0
`define CG_FREE_PCI_BIT 6
`define CG_REF_BIT 0
`define CG_APIC_MSB 5
`define CG_APIC_LSB 4

// ************************************************************
// Power-up values, byte 6 down to byte 0
// ************************************************************
`define CG_RESET_REGS 56'h00_310F_FF7F_0F0C

`endif

// *** inc/clock_gen_pkg.sv ***
// Types shared by the clock generator output control
package clock_gen_pkg;

	// Serial slave states, Gray along idle-receive-ack
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RECV = 2'h1,
		ST_ACK = 2'h3,
		ST_SKIP = 2'h2
	} i2c_state_t;

	// Function-select field of register byte 0
	typedef enum logic [1:0] {
		FN_NORMAL = 2'h0,
		FN_TEST = 2'h1,
		FN_TEST_RSV = 2'h2,
		FN_TRISTATE = 2'h3
	} func_sel_t;

	typedef logic [6:0][7:0] reg_file_t;

endpackage : clock_gen_pkg

// *** logic/clock_source_gen.sv ***
// Source clock levels from the oscillator divider or the test clock
`timescale 1ns/1ns
module clock_source_gen (
	input wire logic sys_clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic xtal_in, // Crystal or test clock level
	input wire logic test_mode, // Derive sources from test clock
	input wire logic osc_on, // Oscillator and VCOs running
	output logic cpu_src, // Processor and memory source level
	output logic pci_src, // PCI source level
	output logic ref_src // Reference source level
);

	logic [1:0] div_q, div_d;
	logic [1:0] tdiv_q, tdiv_d;
	logic xtal_q, xtal_p_q;

	// Divider advances only while the oscillator runs
	always_comb begin
		div_d = div_q;
		tdiv_d = tdiv_q;
		if (osc_on) begin
			div_d = div_q + 2'h1;
			if (xtal_q && !xtal_p_q) begin
				tdiv_d = tdiv_q + 2'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= 2'h0;
			tdiv_q <= 2'h0;
			xtal_q <= 1'b0;
			xtal_p_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tdiv_q <= tdiv_d;
			xtal_q <= xtal_in;
			xtal_p_q <= xtal_q;
		end
	end

	// Test mode takes the test clock instead of the divider
	assign cpu_src = osc_on & (test_mode ? tdiv_q[0] : div_q[0]);
	assign pci_src = osc_on & (test_mode ? tdiv_q[1] : div_q[1]);
	assign ref_src = osc_on & xtal_q;

endmodule : clock_source_gen

// *** logic/clock_gate_cell.sv ***
// Glitch-free stop and start gate for a group of clock outputs
`timescale 1ns/1ns
module clock_gate_cell #(
	parameter int WIDTH = 1,
	parameter bit SYNC_FREE = 1'b1
) (
	input wire logic sys_clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic src, // Source clock level
	input wire logic free_src, // Free-running PCI source level
	input wire logic [WIDTH-1:0] allow, // Output wanted running
	input wire logic kill, // Power-down, force low
	output logic [WIDTH-1:0] clk_out // Gated clock outputs
);

	logic src_p_q, free_p_q;
	logic [WIDTH-1:0] armed_q, armed_d, run_q, run_d, out_q, out_d;
	logic free_rise, src_fall;

	// Arm after a free PCI rise, switch on a source fall
	always_comb begin
		free_rise = free_src & ~free_p_q;
		src_fall = ~src & src_p_q;
		armed_d = armed_q;
		run_d = run_q;
		for (int i = 0; i < WIDTH; i++) begin
			if (run_q[i] == allow[i]) begin
				armed_d[i] = 1'b0;
			end else if (free_rise || !SYNC_FREE) begin
				armed_d[i] = 1'b1;
			end
			if (armed_q[i] && src_fall) begin
				run_d[i] = allow[i];
			end
		end
		out_d = kill ? '0 : (run_d & {WIDTH{src}});
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			src_p_q <= 1'b0;
			free_p_q <= 1'b0;
			armed_q <= '0;
			run_q <= '1;
			out_q <= '0;
		end else begin
			src_p_q <= src;
			free_p_q <= free_src;
			armed_q <= armed_d;
			run_q <= run_d;
			out_q <= out_d;
		end
	end

	assign clk_out = out_q;

	property p_stopped_low;
		@(posedge sys_clk) disable iff (!rst_b) (out_q & ~run_q) == '0;
	endproperty
	a_stopped_low: assert property (p_stopped_low) else $error("stopped output not low");

	property p_switch_while_low;
		@(posedge sys_clk) disable iff (!rst_b) (run_q != $past(run_q)) |-> !src_p_q;
	endproperty
	a_switch_while_low: assert property (p_switch_while_low) else $error("gate switched while high");

	property p_switch_armed;
		@(posedge sys_clk) disable iff (!rst_b) ((run_q ^ $past(run_q)) & ~$past(armed_q)) == '0;
	endproperty
	a_switch_armed: assert property (p_switch_armed) else $error("gate switched without arming");

endmodule : clock_gate_cell

// *** logic/clock_gen_output_control.sv ***
// Output control of the clock generator: serial slave, registers, gating
//
// What this block does
// - Any stopped clock output is held low.
// - No shortened high pulse when an output starts or stops.
// - Processor and PCI start or stop waits free PCI rise, then the clock's fall; memory, reference and interrupt wait the fall only.
// - Free-running PCI clock ignores PCI stop; stops only on its register bit or in power-down.
// - Strap low turns three memory clock pins into control inputs.
// - Output runs only if register bit and control pins allow.
// - Power-down low forces all outputs low and oscillator off.
// - Processor stop low stops processor clocks only.
// - PCI stop low stops gated PCI clocks only.
// - Output-enable low tri-states every output, logic keeps running.
// - Output-enable ORs with tri-state code, never changes the field.
// - Serial port is write-only, no read-back.
// - Whole bytes, MSB first, each followed by an acknowledge.
// - Acknowledge up to 10 bytes written to D2, ignore others.
// - Registers keep their values until a new accepted write.
// - Command and count bytes are acknowledged and ignored.
// - Power-up defaults only at true power-up, not power-down.
// - Function field: 11 tri-state, 10 test reserved, 01 test, 00 normal.
// - Test mode derives outputs from test clock on crystal pin.
`timescale 1ns/1ns
`include "clock_gen_params.svh"
module clock_gen_output_control (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic rst_b, // True power-up reset, active low
	input wire logic serial_clock_pin, // Serial clock level
	input wire logic serial_data_pin_in, // Serial data level
	output logic serial_data_pin_out, // Serial data drive value
	output logic serial_data_pin_oe, // Serial data driven low for ack
	input wire logic xtal_in, // Crystal or test clock level
	input wire logic out_enable_pin, // Output enable, low tri-states
	input wire logic mode_pin, // Strap, low selects control inputs
	input wire logic [2:0] shared_pin_in, // Pins 31, 29, 28 input levels
	output logic [3:0] processor_clock_out, // Processor clocks
	output logic processor_clock_oe, // Processor clock drive enable
	output logic [5:0] gated_pci_clock_out, // Stoppable PCI clocks
	output logic gated_pci_clock_oe, // Gated PCI drive enable
	output logic free_running_pci_clock, // Free-running PCI clock
	output logic free_running_pci_oe, // Free PCI drive enable
	output logic [11:0] sdram_clock_out, // Memory clocks
	output logic [11:0] sdram_clock_oe, // Memory clock drive enables
	output logic ref_clock_out, // Buffered reference clock
	output logic ref_clock_oe, // Reference drive enable
	output logic [1:0] interrupt_ctrl_clock_out, // Interrupt controller clocks
	output logic interrupt_ctrl_clock_oe, // Interrupt clock drive enable
	output logic osc_enable // Oscillator and VCOs running
);

	// ************************************************************
	// Pin sampling
	// ************************************************************

	logic scl_q, scl_p_q, sda_q, sda_p_q;
	logic mode_q, oe_q, pd_q, cpu_stop_q, pci_stop_q;
	logic pd_d, cpu_stop_d, pci_stop_d;

	// Shared pins act as controls only with the strap low
	always_comb begin
		pd_d = ~mode_q & ~shared_pin_in[0];
		cpu_stop_d = ~mode_q & ~shared_pin_in[1];
		pci_stop_d = ~mode_q & ~shared_pin_in[2];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_q <= 1'b1;
			sda_p_q <= 1'b1;
			mode_q <= 1'b1;
			oe_q <= 1'b1;
			pd_q <= 1'b0;
			cpu_stop_q <= 1'b0;
			pci_stop_q <= 1'b0;
		end else begin
			scl_q <= serial_clock_pin;
			scl_p_q <= scl_q;
			sda_q <= serial_data_pin_in;
			sda_p_q <= sda_q;
			mode_q <= mode_pin;
			oe_q <= out_enable_pin;
			pd_q <= pd_d;
			cpu_stop_q <= cpu_stop_d;
			pci_stop_q <= pci_stop_d;
		end
	end

	// ************************************************************
	// Serial write-only slave
	// ************************************************************

	clock_gen_pkg::i2c_state_t st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [3:0] bitc_q, bitc_d;
	logic [3:0] bidx_q, bidx_d;
	logic sda_oe_q, sda_oe_d;
	logic scl_rise, scl_fall, start_c, stop_c, byte_ok, wr_fire;
	logic [3:0] wr_off;
	logic [2:0] wr_idx;

	// Bus conditions seen on the sampled lines
	always_comb begin
		scl_rise = scl_q & ~scl_p_q;
		scl_fall = ~scl_q & scl_p_q;
		start_c = scl_q & scl_p_q & sda_p_q & ~sda_q;
		stop_c = scl_q & scl_p_q & ~sda_p_q & sda_q;
		wr_off = bidx_q - `CG_FIRST_DATA;
		wr_idx = wr_off[2:0];
	end

	// Byte receiver and acknowledge driver
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bitc_d = bitc_q;
		bidx_d = bidx_q;
		sda_oe_d = sda_oe_q;
		wr_fire = 1'b0;
		if (bidx_q == 4'h0) begin
			byte_ok = (sh_q == `CG_SLAVE_ADDR);
		end else begin
			byte_ok = (bidx_q <= `CG_MAX_BYTES);
		end
		if (stop_c) begin
			st_d = clock_gen_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
		end else if (start_c) begin
			st_d = clock_gen_pkg::ST_RECV;
			bitc_d = 4'h0;
			bidx_d = 4'h0;
			sda_oe_d = 1'b0;
		end else begin
			unique case (st_q)
				clock_gen_pkg::ST_IDLE: begin
				end
				clock_gen_pkg::ST_RECV: begin
					if (scl_rise && bitc_q < `CG_BITS_PER_BYTE) begin
						sh_d = {sh_q[6:0], sda_q};
						bitc_d = bitc_q + 4'h1;
					end else if (scl_fall && bitc_q == `CG_BITS_PER_BYTE) begin
						if (byte_ok) begin
							st_d = clock_gen_pkg::ST_ACK;
							sda_oe_d = 1'b1;
							wr_fire = (bidx_q >= `CG_FIRST_DATA) &&
								(bidx_q < `CG_FIRST_DATA + `CG_NUM_REGS);
						end else begin
							st_d = clock_gen_pkg::ST_SKIP;
						end
					end
				end
				clock_gen_pkg::ST_ACK: begin
					if (scl_fall) begin
						st_d = clock_gen_pkg::ST_RECV;
						sda_oe_d = 1'b0;
						bitc_d = 4'h0;
						bidx_d = bidx_q + 4'h1;
					end
				end
				clock_gen_pkg::ST_SKIP: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= clock_gen_pkg::ST_IDLE;
			sh_q <= 8'h00;
			bitc_q <= 4'h0;
			bidx_q <= 4'h0;
			sda_oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			bitc_q <= bitc_d;
			bidx_q <= bidx_d;
			sda_oe_q <= sda_oe_d;
		end
	end

	// Data line is only ever pulled low, never driven with data
	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe = sda_oe_q;

	// ************************************************************
	// Control registers
	// ************************************************************

	clock_gen_pkg::reg_file_t regs_q, regs_d;

	// Accepted data byte lands in its register byte
	always_comb begin
		regs_d = regs_q;
		if (wr_fire) begin
			regs_d[wr_idx] = sh_q;
		end
	end

	// Only the power-up reset loads defaults
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			regs_q <= `CG_RESET_REGS;
		end else begin
			regs_q <= regs_d;
		end
	end

	// ************************************************************
	// Output enables and run permissions
	// ************************************************************

	clock_gen_pkg::func_sel_t func;
	logic test_mode, drive_c;
	logic [3:0] cpu_allow;
	logic [5:0] gpci_allow;
	logic [11:0] sdram_allow, sdram_oe_d;
	logic [1:0] apic_allow;
	logic proc_oe_q, gpci_oe_q, free_oe_q, ref_oe_q, apic_oe_q, osc_q;
	logic [11:0] sdram_oe_q;

	// Register enables combined with stop pins
	always_comb begin
		func = clock_gen_pkg::func_sel_t'(regs_q[`CG_BYTE_FUNC][`CG_FUNC_MSB:`CG_FUNC_LSB]);
		test_mode = (func == clock_gen_pkg::FN_TEST);
		drive_c = oe_q & (func != clock_gen_pkg::FN_TRISTATE);
		cpu_allow = regs_q[`CG_BYTE_CPU][3:0] & {4{~cpu_stop_q}};
		gpci_allow = regs_q[`CG_BYTE_PCI][5:0] & {6{~pci_stop_q}};
		sdram_allow = {regs_q[`CG_BYTE_SDRAM_HI][3:0], regs_q[`CG_BYTE_SDRAM_LO][7:5] & {3{mode_q}},
			regs_q[`CG_BYTE_SDRAM_LO][4:0]};
		apic_allow = regs_q[`CG_BYTE_PERIPH][`CG_APIC_MSB:`CG_APIC_LSB];
		sdram_oe_d = {{4{drive_c}}, {3{drive_c & mode_q}}, {5{drive_c}}};
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			proc_oe_q <= 1'b0;
			gpci_oe_q <= 1'b0;
			free_oe_q <= 1'b0;
			ref_oe_q <= 1'b0;
			apic_oe_q <= 1'b0;
			sdram_oe_q <= 12'h000;
			osc_q <= 1'b0;
		end else begin
			proc_oe_q <= drive_c;
			gpci_oe_q <= drive_c;
			free_oe_q <= drive_c;
			ref_oe_q <= drive_c;
			apic_oe_q <= drive_c;
			sdram_oe_q <= sdram_oe_d;
			osc_q <= ~pd_q;
		end
	end

	assign processor_clock_oe = proc_oe_q;
	assign gated_pci_clock_oe = gpci_oe_q;
	assign free_running_pci_oe = free_oe_q;
	assign ref_clock_oe = ref_oe_q;
	assign interrupt_ctrl_clock_oe = apic_oe_q;
	assign sdram_clock_oe = sdram_oe_q;
	assign osc_enable = osc_q;

	// ************************************************************
	// Sources and gates
	// ************************************************************

	logic cpu_src, pci_src, ref_src;

	clock_source_gen u_src (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.xtal_in(xtal_in),
		.test_mode(test_mode),
		.osc_on(~pd_q),
		.cpu_src(cpu_src),
		.pci_src(pci_src),
		.ref_src(ref_src)
	);

	clock_gate_cell #(.WIDTH(4), .SYNC_FREE(1'b1)) u_cpu (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(cpu_src), .free_src(pci_src),
		.allow(cpu_allow), .kill(pd_q), .clk_out(processor_clock_out)
	);

	clock_gate_cell #(.WIDTH(6), .SYNC_FREE(1'b1)) u_gpci (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(pci_src), .free_src(pci_src),
		.allow(gpci_allow), .kill(pd_q), .clk_out(gated_pci_clock_out)
	);

	// Free PCI clock sees no stop pin, only its enable and power-down
	clock_gate_cell #(.WIDTH(1), .SYNC_FREE(1'b1)) u_free (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(pci_src), .free_src(pci_src),
		.allow(regs_q[`CG_BYTE_PCI][`CG_FREE_PCI_BIT]), .kill(pd_q), .clk_out(free_running_pci_clock)
	);

	clock_gate_cell #(.WIDTH(12), .SYNC_FREE(1'b0)) u_sdram (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(cpu_src), .free_src(pci_src),
		.allow(sdram_allow), .kill(pd_q), .clk_out(sdram_clock_out)
	);

	clock_gate_cell #(.WIDTH(1), .SYNC_FREE(1'b0)) u_ref (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(ref_src), .free_src(pci_src),
		.allow(regs_q[`CG_BYTE_PERIPH][`CG_REF_BIT]), .kill(pd_q), .clk_out(ref_clock_out)
	);

	clock_gate_cell #(.WIDTH(2), .SYNC_FREE(1'b0)) u_apic (
		.sys_clk(sys_clk), .rst_b(rst_b), .src(ref_src), .free_src(pci_src),
		.allow(apic_allow), .kill(pd_q), .clk_out(interrupt_ctrl_clock_out)
	);

	// ************************************************************
	// Checks
	// ************************************************************

	property p_pd_low;
		@(posedge sys_clk) disable iff (!rst_b) pd_q |=> (processor_clock_out == 4'h0 &&
			gated_pci_clock_out == 6'h00 && !free_running_pci_clock && sdram_clock_out == 12'h000 &&
			!ref_clock_out && interrupt_ctrl_clock_out == 2'h0 && !osc_enable);
	endproperty
	a_pd_low: assert property (p_pd_low) else $error("outputs not low in power-down");

	property p_oe_tristate;
		@(posedge sys_clk) disable iff (!rst_b) !oe_q |=> (!processor_clock_oe && !gated_pci_clock_oe &&
			!free_running_pci_oe && sdram_clock_oe == 12'h000 && !ref_clock_oe && !interrupt_ctrl_clock_oe);
	endproperty
	a_oe_tristate: assert property (p_oe_tristate) else $error("output enable low did not tri-state");

	property p_func_tristate;
		@(posedge sys_clk) disable iff (!rst_b)
			(func == clock_gen_pkg::FN_TRISTATE) |=> (!processor_clock_oe && !gated_pci_clock_oe);
	endproperty
	a_func_tristate: assert property (p_func_tristate) else $error("tri-state code ignored");

	property p_strap_inputs;
		@(posedge sys_clk) disable iff (!rst_b) !mode_q |=> sdram_clock_oe[7:5] == 3'h0;
	endproperty
	a_strap_inputs: assert property (p_strap_inputs) else $error("shared pins driven in input mode");

	property p_strap_outputs;
		@(posedge sys_clk) disable iff (!rst_b) mode_q |=> (!pd_q && !cpu_stop_q && !pci_stop_q);
	endproperty
	a_strap_outputs: assert property (p_strap_outputs) else $error("control active with strap high");

	property p_cpu_stop;
		@(posedge sys_clk) disable iff (!rst_b)
			(cpu_stop_q && !pd_q && func != clock_gen_pkg::FN_TEST)[*8] |-> processor_clock_out == 4'h0;
	endproperty
	a_cpu_stop: assert property (p_cpu_stop) else $error("processor clock running while stopped");

	property p_pci_stop;
		@(posedge sys_clk) disable iff (!rst_b)
			(pci_stop_q && !pd_q && func != clock_gen_pkg::FN_TEST)[*8] |=> gated_pci_clock_out == 6'h00;
	endproperty
	a_pci_stop: assert property (p_pci_stop) else $error("gated PCI clock running while stopped");

	property p_free_runs;
		@(posedge sys_clk) disable iff (!rst_b)
			(!pd_q && regs_q[`CG_BYTE_PCI][`CG_FREE_PCI_BIT] && func != clock_gen_pkg::FN_TEST)[*8]
			|=> ##[0:3] free_running_pci_clock;
	endproperty
	a_free_runs: assert property (p_free_runs) else $error("free PCI clock not toggling");

	property p_cpu_enable;
		@(posedge sys_clk) disable iff (!rst_b)
			(!regs_q[`CG_BYTE_CPU][0] && !pd_q && func != clock_gen_pkg::FN_TEST)[*8] |-> !processor_clock_out[0];
	endproperty
	a_cpu_enable: assert property (p_cpu_enable) else $error("disabled processor clock running");

	property p_regs_hold;
		@(posedge sys_clk) disable iff (!rst_b) !wr_fire |=> regs_q == $past(regs_q);
	endproperty
	a_regs_hold: assert property (p_regs_hold) else $error("register changed without write");

	property p_regs_default;
		@(posedge sys_clk) disable iff (!rst_b) !$past(rst_b) |-> regs_q == `CG_RESET_REGS;
	endproperty
	a_regs_default: assert property (p_regs_default) else $error("power-up defaults wrong");

	property p_write_lands;
		@(posedge sys_clk) disable iff (!rst_b) wr_fire |=> regs_q[$past(wr_idx)] == $past(sh_q);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("data byte not stored");

	property p_ack_after_byte;
		@(posedge sys_clk) disable iff (!rst_b)
			$rose(sda_oe_q) |-> ($past(bitc_q) == `CG_BITS_PER_BYTE && $past(scl_fall));
	endproperty
	a_ack_after_byte: assert property (p_ack_after_byte) else $error("ack not after eighth bit");

	property p_ack_addressed;
		@(posedge sys_clk) disable iff (!rst_b) $rose(sda_oe_q) |->
			(($past(bidx_q) == 4'h0 && $past(sh_q) == `CG_SLAVE_ADDR) ||
			($past(bidx_q) != 4'h0 && $past(bidx_q) <= `CG_MAX_BYTES));
	endproperty
	a_ack_addressed: assert property (p_ack_addressed) else $error("ack outside addressed write");

	property p_skip_header;
		@(posedge sys_clk) disable iff (!rst_b) $rose(sda_oe_q) && $past(bidx_q) < `CG_FIRST_DATA |-> $stable(regs_q);
	endproperty
	a_skip_header: assert property (p_skip_header) else $error("command or count byte stored");

	property p_no_readback;
		@(posedge sys_clk) disable iff (!rst_b) sda_oe_q |-> (!serial_data_pin_out && st_q == clock_gen_pkg::ST_ACK);
	endproperty
	a_no_readback: assert property (p_no_readback) else $error("data line driven high");

endmodule : clock_gen_output_control

// *** verif/serial_host_model.sv ***
// Two-wire host model that writes register bytes to the clock generator
`timescale 1ns/1ns
module serial_host_model (
	input wire logic sys_clk, // System clock
	input wire logic sda_wire, // Resolved data line
	output logic scl, // Serial clock drive
	output logic sda_low // Host pulls data low
);
	// Both lines released while idle
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Half bit time, well above the three-cycle minimum
	task automatic half;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask : half
	// Start, address first, all bytes in order, ack per byte, then stop
	task automatic xfer(input logic [7:0] b [12], input int n, output logic [15:0] acks);
		acks = '0;
		sda_low = 1'b1;
		half();
		for (int i = 0; i < n; i++) begin
			for (int k = 7; k >= 0; k--) begin
				scl = 1'b0;
				sda_low = ~b[i][k];
				half();
				scl = 1'b1;
				half();
			end
			scl = 1'b0;
			sda_low = 1'b0;
			half();
			scl = 1'b1;
			half();
			acks[i] = ~sda_wire;
		end
		scl = 1'b0;
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask : xfer
endmodule : serial_host_model

// *** verif/tb_clock_gen_output_control.sv ***
// Self-checking bench for the clock generator output control
`timescale 1ns/1ns
module tb_clock_gen_output_control;
	logic sys_clk, rst_b, scl, host_low, sda_out, sda_oe, xtal_in, oe_pin, mode_pin;
	logic [2:0] shared;
	logic [3:0] cpu;
	logic [5:0] pci;
	logic [11:0] sdr, sdr_oe;
	logic [1:0] apic;
	logic cpu_oe, pci_oe, free, free_oe, ref_clk, ref_oe, apic_oe, osc;
	logic [15:0] acks;
	int num_errors = 0;
	int total_checks = 0;
	// Open-drain data line with pull-up
	wire sda_wire = ~(host_low | (sda_oe & ~sda_out));
	clock_gen_output_control DUT (.sys_clk(sys_clk), .rst_b(rst_b), .serial_clock_pin(scl),
		.serial_data_pin_in(sda_wire), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
		.xtal_in(xtal_in), .out_enable_pin(oe_pin), .mode_pin(mode_pin), .shared_pin_in(shared),
		.processor_clock_out(cpu), .processor_clock_oe(cpu_oe), .gated_pci_clock_out(pci),
		.gated_pci_clock_oe(pci_oe), .free_running_pci_clock(free), .free_running_pci_oe(free_oe),
		.sdram_clock_out(sdr), .sdram_clock_oe(sdr_oe), .ref_clock_out(ref_clk), .ref_clock_oe(ref_oe),
		.interrupt_ctrl_clock_out(apic), .interrupt_ctrl_clock_oe(apic_oe), .osc_enable(osc));
	serial_host_model host (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(host_low));
	// ************************************************************
	// Checking helpers
	// ************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// Which groups ran: processor, gated PCI, free PCI, memory 0, reference, interrupt
	task automatic activity(input logic [5:0] exp);
		logic [5:0] seen;
		seen = '0;
		repeat (15) @(posedge sys_clk);
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			seen |= {|cpu, |pci, free, sdr[0], ref_clk, |apic};
		end
		check({10'h0, seen}, {10'h0, exp});
	endtask : activity
	task automatic enables(input logic [5:0] exp);
		repeat (6) @(posedge sys_clk);
		#1;
		check({10'h0, cpu_oe, pci_oe, free_oe, ref_oe, apic_oe, osc}, {10'h0, exp});
	endtask : enables
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_defaults;
		enables(6'h3F);
		check({4'h0, sdr_oe}, 16'h0FFF);
		activity(6'h3F);
		oe_pin = 1'b0;
		enables(6'h01);
		oe_pin = 1'b1;
	endtask : test_defaults
	task automatic test_write;
		host.xfer('{8'hD2, 8'h5A, 8'hA5, 8'h0C, 8'h00, 0, 0, 0, 0, 0, 0, 0}, 5, acks);
		check(acks, 16'h001F);
		activity(6'h1F);
		host.xfer('{8'hD4, 8'h00, 8'h00, 8'h0C, 8'h0F, 0, 0, 0, 0, 0, 0, 0}, 5, acks);
		check(acks, 16'h0000);
		activity(6'h1F);
	endtask : test_write
	task automatic test_tristate;
		host.xfer('{8'hD2, 8'h00, 8'h00, 8'h0F, 0, 0, 0, 0, 0, 0, 0, 0}, 4, acks);
		check(acks, 16'h000F);
		enables(6'h01);
		oe_pin = 1'b0;
		enables(6'h01);
		oe_pin = 1'b1;
		enables(6'h01);
		host.xfer('{8'hD2, 0, 0, 8'h0C, 8'h0F, 8'h7F, 8'hFF, 8'h0F, 8'h31, 0, 8'h55, 8'hAA}, 12, acks);
		check(acks, 16'h07FF);
		enables(6'h3F);
		activity(6'h3F);
	endtask : test_tristate
	// Test code: processor clock follows the slow test clock, not the divider
	task automatic test_testmode;
		int rises;
		logic prev;
		host.xfer('{8'hD2, 0, 0, 8'h0D, 0, 0, 0, 0, 0, 0, 0, 0}, 4, acks);
		check(acks, 16'h000F);
		repeat (30) @(posedge sys_clk);
		#1;
		rises = 0;
		prev = cpu[0];
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			if (cpu[0] && !prev) rises++;
			prev = cpu[0];
		end
		check({15'h0, rises inside {[2:4]}}, 16'h0001);
		activity(6'h3F);
		host.xfer('{8'hD2, 0, 0, 8'h0C, 0, 0, 0, 0, 0, 0, 0, 0}, 4, acks);
		check(acks, 16'h000F);
	endtask : test_testmode
	task automatic test_pins;
		shared = 3'b000;
		activity(6'h3F);
		mode_pin = 1'b0;
		shared = 3'b101;
		activity(6'h1F);
		check({13'h0, sdr_oe[7:5]}, 16'h0000);
		shared = 3'b011;
		activity(6'h2F);
		host.xfer('{8'hD2, 0, 0, 8'h0C, 8'h00, 0, 0, 0, 0, 0, 0, 0}, 5, acks);
		check(acks, 16'h001F);
		shared = 3'b110;
		activity(6'h00);
		check({15'h0, osc}, 16'h0000);
		shared = 3'b111;
		repeat (20) @(posedge sys_clk);
		activity(6'h1F);
	endtask : test_pins
	// ************************************************************
	// Clocks, reset, sequence, watchdog
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		xtal_in = 1'b0;
		forever #34 xtal_in = ~xtal_in;
	end
	initial begin
		rst_b = 1'b0;
		oe_pin = 1'b1;
		mode_pin = 1'b1;
		shared = 3'b111;
		repeat (12) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		test_defaults();
		test_write();
		test_tristate();
		test_testmode();
		test_pins();
		tally_and_finish();
	end
	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end
endmodule : tb_clock_gen_output_control
